// ---- tbs_pkg.sv ----
`default_nettype none
package tbs_pkg;
	// system clock
	localparam int CLK_HZ = 40_000_000;
	localparam int CYC_PER_US = CLK_HZ / 1_000_000;
	// fallback wake in slow mode
	localparam int SLEEP_MS = 90;
	localparam int SLEEP_CYC = SLEEP_MS * 1000 * CYC_PER_US;
	// acquisition pulse timing
	localparam int ACQ_PERIOD_NS = 10_000;
	localparam int ACQ_PERIOD_CYC = ACQ_PERIOD_NS * CYC_PER_US / 1000;
	localparam int ACQ_PULSE_NS = 2_000;
	localparam int ACQ_PULSE_CYC = ACQ_PULSE_NS * CYC_PER_US / 1000;
	localparam int BURST_PULSES = 250;
	localparam int BURST_US = BURST_PULSES * ACQ_PERIOD_NS / 1000;
	// self-timed gap between bursts in fast mode
	localparam int FAST_GAP_MS = 4;
	localparam int FAST_GAP_CYC = FAST_GAP_MS * 1000 * CYC_PER_US;
	// assumed sync rate
	localparam int SYNC_HZ = 55;
	localparam int SYNC_PERIOD_US = 1_000_000 / SYNC_HZ;
	localparam int SLOW_PERIOD_US = SLEEP_MS * 1000 + BURST_US;
	// nominal durations expressed later as burst counts
	localparam int MAXON_MS = 10_000;
	localparam int DRIFT_POS_MS = 1_000;
	localparam int DRIFT_NEG_MS = 250;
	localparam int CONSENSUS_LEN = 6;
	localparam int TIMER_W = 22;
	localparam int BURSTS_W = 16;
	localparam int CHANNELS = 4;

	function automatic int bursts_for(input int ms, input int period_us);
		int n;
		n = (ms * 1000 + period_us / 2) / period_us;
		return (n < 1) ? 1 : n;
	endfunction

	localparam int MAXON_SYNC = bursts_for(MAXON_MS, SYNC_PERIOD_US);
	localparam int DRIFT_POS_SYNC = bursts_for(DRIFT_POS_MS, SYNC_PERIOD_US);
	localparam int DRIFT_NEG_SYNC = bursts_for(DRIFT_NEG_MS, SYNC_PERIOD_US);
	localparam int MAXON_SLOW = bursts_for(MAXON_MS, SLOW_PERIOD_US);
	localparam int DRIFT_POS_SLOW = bursts_for(DRIFT_POS_MS, SLOW_PERIOD_US);
	localparam int DRIFT_NEG_SLOW = bursts_for(DRIFT_NEG_MS, SLOW_PERIOD_US);
endpackage
`default_nettype wire

// ---- tbs_consensus.sv ----
`timescale 1ns/100ps
`default_nettype none
module tbs_consensus #(
	parameter int CHANNELS = 4,
	parameter int LIMIT = 6
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic sample_i,
	input wire logic [CHANNELS-1:0] hit_i,
	output logic [CHANNELS-1:0] key_o,
	output logic pending_o
);
	localparam int CW = $clog2(LIMIT + 1);

	typedef struct packed {
		logic [CHANNELS-1:0][CW-1:0] cnt;
		logic [CHANNELS-1:0] key;
		logic pending;
	} tbs_cons_t;

	tbs_cons_t s;
	tbs_cons_t next_s;

	if (LIMIT < 1 || CHANNELS < 1)
	begin : g_bad_cfg
		$error("consensus length and channel count must be positive");
	end

	always_comb
	begin
		next_s = s;
		if (sample_i)
		begin
			for (int ch = 0; ch < CHANNELS; ch++)
			begin
				if (!hit_i[ch])
				begin
					// one miss throws the pending detection away
					next_s.cnt[ch] = '0;
					next_s.key[ch] = 1'b0;
				end
				else if (s.cnt[ch] != CW'(LIMIT))
				begin
					next_s.cnt[ch] = s.cnt[ch] + CW'(1);
					if (s.cnt[ch] == CW'(LIMIT - 1))
						next_s.key[ch] = 1'b1;
				end
			end
		end
		next_s.pending = 1'b0;
		for (int ch = 0; ch < CHANNELS; ch++)
		begin
			if (next_s.cnt[ch] != '0 && !next_s.key[ch])
				next_s.pending = 1'b1;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
			s <= '0;
		else
			s <= next_s;
	end

	assign key_o = s.key;
	assign pending_o = s.pending;

	confirm_on_sixth_a:
	assert property (@(posedge clk_i) disable iff (!nrst_i)
		sample_i && hit_i[0] && s.cnt[0] == CW'(LIMIT - 1) |=> key_o[0])
	else $error("detection not confirmed on final positive sample");

	miss_discards_a:
	assert property (@(posedge clk_i) disable iff (!nrst_i)
		sample_i && !hit_i[0] |=> s.cnt[0] == '0 && !key_o[0])
	else $error("failed sample did not discard pending detection");

	no_early_key_a:
	assert property (@(posedge clk_i) disable iff (!nrst_i)
		$rose(key_o[0]) |-> $past(s.cnt[0]) == CW'(LIMIT - 1))
	else $error("detection confirmed before enough samples");
endmodule // tbs_consensus
`default_nettype wire

// ---- tbs_burst_sync.sv ----
`timescale 1ns/100ps
`default_nettype none
module tbs_burst_sync #(
	parameter int SLEEP_CYC = tbs_pkg::SLEEP_CYC,
	parameter int FAST_GAP_CYC = tbs_pkg::FAST_GAP_CYC,
	parameter int BURST_PULSES = tbs_pkg::BURST_PULSES,
	parameter int CONSENSUS_LEN = tbs_pkg::CONSENSUS_LEN
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic speed_strap_i,
	input wire logic sync_i,
	output logic sync_o,
	output logic sync_oe_o,
	input wire logic [tbs_pkg::CHANNELS-1:0] detect_i,
	output logic [tbs_pkg::CHANNELS-1:0] sense_pin_o,
	output logic bias_current_node_en_o,
	output logic slow_mode_o,
	output logic [tbs_pkg::CHANNELS-1:0] key_o,
	output logic [tbs_pkg::CHANNELS-1:0] recal_o,
	output logic drift_pos_tick_o,
	output logic drift_neg_tick_o
);
	localparam int CH = tbs_pkg::CHANNELS;
	localparam int TW = tbs_pkg::TIMER_W;
	localparam int BW = tbs_pkg::BURSTS_W;
	localparam int PER = tbs_pkg::ACQ_PERIOD_CYC;
	localparam int PW = tbs_pkg::ACQ_PULSE_CYC;
	localparam int FAST_PERIOD_US =
		FAST_GAP_CYC / tbs_pkg::CYC_PER_US +
		BURST_PULSES * tbs_pkg::ACQ_PERIOD_NS / 1000;
	localparam int MAXON_FAST =
		tbs_pkg::bursts_for(tbs_pkg::MAXON_MS, FAST_PERIOD_US);
	localparam int DRIFT_POS_FAST =
		tbs_pkg::bursts_for(tbs_pkg::DRIFT_POS_MS, FAST_PERIOD_US);
	localparam int DRIFT_NEG_FAST =
		tbs_pkg::bursts_for(tbs_pkg::DRIFT_NEG_MS, FAST_PERIOD_US);

	if (SLEEP_CYC < 2 || SLEEP_CYC >= 2 ** TW || FAST_GAP_CYC < 2 ||
		FAST_GAP_CYC >= 2 ** TW || BURST_PULSES < 2 ||
		BURST_PULSES > 511 || PW >= PER)
	begin : g_bad_cfg
		$error("timing parameters out of range for counter widths");
	end

	typedef enum logic [1:0] {
		TBS_SLEEP = 2'b00,
		TBS_BURST = 2'b01,
		TBS_DONE = 2'b11,
		TBS_ARM = 2'b10
	} tbs_state_e_t;

	typedef struct packed {
		tbs_state_e_t st;
		logic [1:0] strap_ff;
		logic [2:0] sync_ff;
		logic [CH-1:0] det_ff1;
		logic [CH-1:0] det_ff2;
		logic [1:0] boot;
		logic slow;
		logic sync_seen;
		logic [TW-1:0] tmr;
		logic [8:0] phase;
		logic [8:0] pcount;
		logic pulse;
		logic osc_en;
		logic sync_drv;
		logic sync_en;
		logic sample;
		logic [BW-1:0] pos_cnt;
		logic [BW-1:0] neg_cnt;
		logic dpos;
		logic dneg;
		logic [CH-1:0][BW-1:0] stuck;
		logic [CH-1:0] recal;
	} tbs_top_t;

	tbs_top_t s;
	tbs_top_t next_s;
	logic booted;
	logic sync_edge;
	logic fb_due;
	logic fast_due;
	logic wake;
	logic pending;
	logic [BW-1:0] lim_max;
	logic [BW-1:0] lim_pos;
	logic [BW-1:0] lim_neg;

	tbs_consensus #(
		.CHANNELS(CH),
		.LIMIT(CONSENSUS_LEN)
	) u_consensus_filter (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.sample_i(s.sample),
		.hit_i(s.det_ff2),
		.key_o(key_o),
		.pending_o(pending)
	);

	always_comb
	begin
		booted = (s.boot == 2'h3);
		// edge taken only while asleep in slow mode
		sync_edge = s.sync_ff[1] & ~s.sync_ff[2] & s.slow &
			(s.st == TBS_SLEEP);
		fb_due = (s.tmr == TW'(SLEEP_CYC - 1));
		fast_due = (s.tmr == TW'(FAST_GAP_CYC - 1));
		// in slow mode confirmation runs back to back without sleeping; fast mode waits for its gap
		wake = booted && (s.slow ? (sync_edge | fb_due | pending) :
			fast_due);
		if (!s.slow)
		begin
			lim_max = BW'(MAXON_FAST);
			lim_pos = BW'(DRIFT_POS_FAST);
			lim_neg = BW'(DRIFT_NEG_FAST);
		end
		else if (s.sync_seen)
		begin
			lim_max = BW'(tbs_pkg::MAXON_SYNC);
			lim_pos = BW'(tbs_pkg::DRIFT_POS_SYNC);
			lim_neg = BW'(tbs_pkg::DRIFT_NEG_SYNC);
		end
		else
		begin
			lim_max = BW'(tbs_pkg::MAXON_SLOW);
			lim_pos = BW'(tbs_pkg::DRIFT_POS_SLOW);
			lim_neg = BW'(tbs_pkg::DRIFT_NEG_SLOW);
		end
	end

	always_comb
	begin
		next_s = s;
		next_s.strap_ff = {s.strap_ff[0], speed_strap_i};
		next_s.sync_ff = {s.sync_ff[1:0], sync_i};
		next_s.det_ff1 = detect_i;
		next_s.det_ff2 = s.det_ff1;
		next_s.sample = 1'b0;
		next_s.dpos = 1'b0;
		next_s.dneg = 1'b0;
		next_s.recal = '0;
		if (!booted)
			next_s.boot = s.boot + 2'h1;
		if (s.boot == 2'h2)
			next_s.slow = s.strap_ff[1];
		// pin driven only in fast mode
		next_s.sync_en = booted & ~s.slow;
		unique case (s.st)
			TBS_SLEEP:
			begin
				next_s.tmr = s.tmr + TW'(1);
				next_s.osc_en = ~s.slow;
				if (wake)
				begin
					next_s.st = TBS_BURST;
					next_s.tmr = '0;
					next_s.phase = '0;
					next_s.pcount = '0;
					next_s.pulse = 1'b1;
					next_s.osc_en = 1'b1;
					next_s.sync_drv = ~s.slow;
					if (sync_edge)
						next_s.sync_seen = 1'b1;
					else if (fb_due)
						next_s.sync_seen = 1'b0;
				end
			end
			TBS_BURST:
			begin
				if (s.phase == 9'(PER - 1))
				begin
					// all channels share one pulse train
					next_s.phase = '0;
					next_s.pcount = s.pcount + 9'h1;
					if (s.pcount == 9'(BURST_PULSES - 1))
					begin
						next_s.st = TBS_DONE;
						next_s.pulse = 1'b0;
					end
					else
						next_s.pulse = 1'b1;
				end
				else
				begin
					next_s.phase = s.phase + 9'h1;
					next_s.pulse = ((s.phase + 9'h1) < 9'(PW));
				end
			end
			TBS_DONE:
			begin
				// clamp the spread pulse low at burst end
				next_s.sync_drv = 1'b0;
				next_s.sample = 1'b1;
				next_s.osc_en = ~s.slow;
				next_s.st = TBS_ARM;
			end
			TBS_ARM:
			begin
				next_s.st = TBS_SLEEP;
				next_s.tmr = '0;
				// timebases advance once per burst
				if (s.pos_cnt >= lim_pos - BW'(1))
				begin
					next_s.pos_cnt = '0;
					next_s.dpos = 1'b1;
				end
				else
					next_s.pos_cnt = s.pos_cnt + BW'(1);
				if (s.neg_cnt >= lim_neg - BW'(1))
				begin
					next_s.neg_cnt = '0;
					next_s.dneg = 1'b1;
				end
				else
					next_s.neg_cnt = s.neg_cnt + BW'(1);
				for (int ch = 0; ch < CH; ch++)
				begin
					if (!key_o[ch])
						next_s.stuck[ch] = '0;
					else if (s.stuck[ch] >= lim_max - BW'(1))
					begin
						next_s.stuck[ch] = '0;
						next_s.recal[ch] = 1'b1;
					end
					else
						next_s.stuck[ch] = s.stuck[ch] + BW'(1);
				end
			end
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
			s <= '0;
		else
			s <= next_s;
	end

	assign sync_o = s.sync_drv;
	assign sync_oe_o = s.sync_en;
	assign sense_pin_o = {CH{s.pulse}};
	assign bias_current_node_en_o = s.osc_en;
	assign slow_mode_o = s.slow;
	assign recal_o = s.recal;
	assign drift_pos_tick_o = s.dpos;
	assign drift_neg_tick_o = s.dneg;

	// spacing helper for pulse checks
	logic pulse_d;
	logic [9:0] gap;
	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
		begin
			pulse_d <= 1'b0;
			gap <= '0;
		end
		else
		begin
			pulse_d <= s.pulse;
			if (s.pulse & ~pulse_d)
				gap <= '0;
			else if (gap != 10'h3ff)
				gap <= gap + 10'h1;
		end
	end

	fast_ignores_sync_a:
	assert property (@(posedge clk_i) disable iff (!nrst_i)
		booted && !s.slow && s.st == TBS_SLEEP && !fast_due
		|=> s.st == TBS_SLEEP)
	else $error("fast mode left sleep before its own gap");

	sync_wakes_a:
	assert property (@(posedge clk_i) disable iff (!nrst_i)
		booted && s.slow && s.st == TBS_SLEEP && sync_edge
		|=> s.st == TBS_BURST && bias_current_node_en_o)
	else $error("sync edge did not start a burst");

	fallback_wake_a:
	assert property (@(posedge clk_i) disable iff (!nrst_i)
		booted && s.slow && s.st == TBS_SLEEP && fb_due && !sync_edge
		|=> s.st == TBS_BURST ##1 !s.sync_seen)
	else $error("fallback wake missed");

	sleep_bounded_a:
	assert property (@(posedge clk_i) disable iff (!nrst_i)
		s.st == TBS_SLEEP && s.slow |-> s.tmr < TW'(SLEEP_CYC))
	else $error("sleep ran past fallback interval");

	stuck_recal_a:
	assert property (@(posedge clk_i) disable iff (!nrst_i)
		s.st == TBS_ARM && key_o[0] && s.stuck[0] == lim_max - BW'(1)
		|=> recal_o[0] && s.stuck[0] == '0)
	else $error("stuck-key timeout not raised at burst limit");

	sync_counts_a:
	assert property (@(posedge clk_i) disable iff (!nrst_i)
		s.slow && s.sync_seen |-> lim_max == BW'(tbs_pkg::MAXON_SYNC)
		&& lim_pos == BW'(tbs_pkg::DRIFT_POS_SYNC))
	else $error("sync burst constants not selected");

	lockstep_a:
	assert property (@(posedge clk_i) disable iff (!nrst_i)
		sense_pin_o == '0 || sense_pin_o == '1)
	else $error("channels pulsed out of lockstep");

	spread_pulse_a:
	assert property (@(posedge clk_i) disable iff (!nrst_i)
		booted && !s.slow && s.st == TBS_DONE
		|=> sync_oe_o && !sync_o ##1 !sync_o)
	else $error("spread pulse not grounded at burst end");

	spread_high_a:
	assert property (@(posedge clk_i) disable iff (!nrst_i)
		booted && !s.slow && s.st == TBS_SLEEP && wake
		|=> sync_o && sync_oe_o)
	else $error("spread pulse not raised at burst start");

	osc_off_a:
	assert property (@(posedge clk_i) disable iff (!nrst_i)
		s.slow && s.st == TBS_SLEEP && !wake |=> !bias_current_node_en_o)
	else $error("oscillator running during slow-mode sleep");

	slow_pin_quiet_a:
	assert property (@(posedge clk_i) disable iff (!nrst_i)
		s.slow && booted |=> !sync_oe_o && !sync_o)
	else $error("pin driven in slow mode");

	pulse_spacing_a:
	assert property (@(posedge clk_i) disable iff (!nrst_i)
		s.pulse && !pulse_d && s.pcount != '0 |-> gap == 10'(PER - 1))
	else $error("acquisition pulses not one period apart");

	strap_held_a:
	assert property (@(posedge clk_i) disable iff (!nrst_i)
		booted |=> $stable(slow_mode_o))
	else $error("speed mode changed after start-up");

	burst_ignores_sync_a:
	assert property (@(posedge clk_i) disable iff (!nrst_i)
		s.st == TBS_BURST && s.pcount != 9'(BURST_PULSES - 1)
		|=> s.st == TBS_BURST)
	else $error("burst broken off early");
endmodule // tbs_burst_sync
`default_nettype wire

// ---- tbs_sync_source.sv ----
`timescale 1ns/100ps
`default_nettype none
module tbs_sync_source #(
	parameter int PERIOD_CYC = 3000
) (
	input wire logic clk_i,
	input wire logic en_i,
	input wire logic inv_i,
	output logic sync_o
);
	int cnt;

	always_ff @(posedge clk_i)
	begin
		if (!en_i)
			cnt <= 0;
		else
			cnt <= (cnt == PERIOD_CYC - 1) ? 0 : cnt + 1;
	end

	// free-running square wave, opposite phase on request
	// held at ground while sync is not wanted
	assign sync_o = en_i ? ((cnt < PERIOD_CYC / 2) ^ inv_i) : 1'b0;
endmodule // tbs_sync_source
`default_nettype wire

// ---- touch_burst_sync_control_test.sv ----
`timescale 1ns/100ps
`default_nettype none
module touch_burst_sync_control_test;
	localparam int SLEEP = 2000;
	localparam int GAP = 500;
	localparam int PULSES = 4;
	localparam int SYNC_PER = 3000;
	localparam int BURST_LEN = PULSES * 400;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic strap = 1'b1;
	logic src_en = 1'b0;
	logic [3:0] detect = 4'h0;
	logic src_sync;
	logic sync_pin;
	logic spread_out;
	logic sync_oe;
	logic [3:0] sense;
	logic osc_en;
	logic slow_mode;
	logic [3:0] key;
	logic start_sig;
	int n_fail = 0;
	int num_checks = 0;
	int cyc = 0;

	// bias node left unmodulated: every burst sees the same drive
	// pin level: device drives while enabled, else the source
	assign sync_pin = sync_oe ? spread_out : src_sync;
	assign start_sig = slow_mode ? osc_en : spread_out;

	tbs_burst_sync #(
		.SLEEP_CYC(SLEEP),
		.FAST_GAP_CYC(GAP),
		.BURST_PULSES(PULSES),
		.CONSENSUS_LEN(tbs_pkg::CONSENSUS_LEN)
	) i_dut (
		.clk_i(clk),
		.nrst_i(nrst),
		.speed_strap_i(strap),
		.sync_i(sync_pin),
		.sync_o(spread_out),
		.sync_oe_o(sync_oe),
		.detect_i(detect),
		.sense_pin_o(sense),
		.bias_current_node_en_o(osc_en),
		.slow_mode_o(slow_mode),
		.key_o(key),
		.recal_o(),
		.drift_pos_tick_o(),
		.drift_neg_tick_o()
	);

	tbs_sync_source #(
		.PERIOD_CYC(SYNC_PER)
	) i_src (
		.clk_i(clk),
		.en_i(src_en),
		.inv_i(1'b0),
		.sync_o(src_sync)
	);

	initial
	begin
		forever #12.5 clk = ~clk;
	end

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			$display("FAIL %s expected %0h seen %0h", what, exp, seen);
			n_fail++;
		end
	endtask

	task automatic tick();
		@(negedge clk);
		cyc++;
	endtask

	task automatic do_reset(input logic s);
		@(posedge clk);
		nrst <= 1'b0;
		strap <= s;
		src_en <= 1'b0;
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		repeat (6) tick();
	endtask

	task automatic wait_start(input int lim, output int t);
		logic p;
		p = start_sig;
		for (t = 0; t < lim; t++)
		begin
			tick();
			if (start_sig && !p)
				return;
			p = start_sig;
		end
		check("burst_start", 0, 1);
		print_verdict();
	endtask

	function automatic logic [3:0] det_of(input int i);
		return (i == 6) ? 4'h0 : (i == 12) ? 4'h1 : 4'h5;
	endfunction

	task automatic slow_sync();
		int t, s0, s1, w, g;
		do_reset(1'b1);
		check("slow_mode", slow_mode, 1);
		check("sync_oe", sync_oe, 0);
		@(posedge clk) src_en <= 1'b1;
		wait_start(12, t);
		s0 = cyc;
		check("wake_latency", t <= 8, 1);
		check("sense_all", sense, 4'hf);
		for (w = 0; sense[0] && w < 500; w++)
			tick();
		for (g = 0; !sense[0] && g < 500; g++)
			tick();
		check("pulse_period", w + g, 400);
		while (cyc < s0 + 2500)
			tick();
		check("osc_sleep", osc_en, 0);
		check("no_spread", {sync_oe, spread_out}, 0);
		wait_start(SYNC_PER, t);
		s1 = cyc;
		check("sync_spacing", s1 - s0, SYNC_PER);
		@(posedge clk) src_en <= 1'b0;
		wait_start(2 * SLEEP + BURST_LEN, t);
		check("fallback", (cyc - s1 >= BURST_LEN + SLEEP) &&
			(cyc - s1 <= BURST_LEN + SLEEP + 12), 1);
	endtask

	task automatic fast_consensus();
		int t, i, k, len;
		int cnt [4];
		logic [3:0] exp_key;
		logic [3:0] det_now;
		cnt = '{default: 0};
		do_reset(1'b0);
		@(posedge clk);
		strap <= 1'b1;
		detect <= det_of(0);
		for (i = 0; i < 14; i++)
		begin
			wait_start(GAP + BURST_LEN + 20, t);
			check("spread_oe", sync_oe, 1);
			check("sense_all", sense, 4'hf);
			for (len = 1; spread_out && len < 2000; len++)
				tick();
			check("spread_len", len >= BURST_LEN &&
				len <= BURST_LEN + 4, 1);
			check("spread_low", {sync_oe, spread_out}, 2'h2);
			repeat (3) tick();
			det_now = det_of(i);
			for (k = 0; k < 4; k++)
			begin
				cnt[k] = det_now[k] ? cnt[k] + 1 : 0;
				exp_key[k] = cnt[k] >= tbs_pkg::CONSENSUS_LEN;
			end
			check("key", key, exp_key);
			@(posedge clk) detect <= det_of(i + 1);
		end
		check("strap_latched", slow_mode, 0);
	endtask

	initial
	begin
		slow_sync();
		fast_consensus();
		print_verdict();
	end
endmodule // touch_burst_sync_control_test
`default_nettype wire
